// ### common/asp_pkg.sv
package asp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_DATA = 12'hf40;
    localparam logic [11:0] IDX_STAT0 = 12'hf41;
    localparam logic [11:0] IDX_CTL0 = 12'hf42;
    localparam logic [11:0] IDX_CTL1 = 12'hf43;
    localparam logic [11:0] IDX_MATCH = 12'hf45;
    localparam logic [11:0] IDX_RATE_HI = 12'hf46;
    localparam logic [11:0] IDX_RATE_LO = 12'hf47;
    localparam logic [11:0] IDX_INTERRUPT_REQUEST_REG_ZERO = 12'hfc0;

    // Reset values
    localparam logic [7:0] CTL0_RST = 8'h00;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] MATCH_RST = 8'h00;
    localparam logic [7:0] RATE_HI_RST = 8'hff;
    localparam logic [7:0] RATE_LO_RST = 8'hff;

    // Control 0 fields
    localparam int TX_EN_BIT = 7;
    localparam int RX_EN_BIT = 6;
    localparam int PAR_EN_BIT = 4;
    localparam int PAR_ODD_BIT = 3;
    // Control 1 fields
    localparam int MD_EN_BIT = 7;
    localparam int MD_FILT_BIT = 6;
    localparam int MD_TXMARK_BIT = 5;
    localparam int AVAIL_MASK_BIT = 4;
    localparam int TMR_IRQ_BIT = 3;
    // Status 0 fields
    localparam int ST_AVAIL_BIT = 7;
    localparam int ST_PERR_BIT = 6;
    localparam int ST_OVR_BIT = 5;
    localparam int ST_FERR_BIT = 4;
    localparam int ST_BRK_BIT = 3;
    localparam int ST_TXE_BIT = 2;
    localparam int ST_MARK_BIT = 1;
    localparam int ST_TMR_BIT = 0;
    // Interrupt request 0 fields
    localparam int IRQ_RX_BIT = 4;
    localparam int IRQ_TX_BIT = 3;

    // Timing: sixteen divisor ticks per bit, receive samples at mid bit
    localparam int unsigned BRG_W = 16;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] BITS_BASE = 4'h8;

    typedef enum logic [3:0] {
        ASP_TX_IDLE = 4'b0001,
        ASP_TX_START = 4'b0010,
        ASP_TX_BITS = 4'b0100,
        ASP_TX_STOP = 4'b1000
    } asp_tx_st_t;

    typedef enum logic [3:0] {
        ASP_RX_IDLE = 4'b0001,
        ASP_RX_START = 4'b0010,
        ASP_RX_BITS = 4'b0100,
        ASP_RX_STOP = 4'b1000
    } asp_rx_st_t;

    typedef struct packed {
        asp_tx_st_t tx_st;
        logic [3:0] tx_tick;
        logic [3:0] tx_bit;
        logic [8:0] tx_shift;
        logic [7:0] tx_hold;
        logic hold_full;
        logic tx_empty;
        logic txd;
        asp_rx_st_t rx_st;
        logic [3:0] rx_tick;
        logic [3:0] rx_bit;
        logic [8:0] rx_shift;
        logic [7:0] rx_data;
        logic rx_avail;
        logic rx_mark;
        logic ovr_pend;
        logic brk_pend;
        logic overrun;
        logic line_break;
        logic framing;
        logic parity_err;
        logic addr_hit;
        logic timer_flag;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] match;
        logic [7:0] rate_hi;
        logic [7:0] rate_lo;
        logic irq_tx;
        logic irq_rx;
        logic tx_req_prev;
        logic rx_req_prev;
        logic wr_pend;
        logic [11:0] wr_idx;
        logic [7:0] hrdata;
    } asp_state_t;

    function automatic logic reg_hit(input logic [31:0] addr, input logic [11:0] idx);
        return addr == {18'h0, idx, 2'b00};
    endfunction : reg_hit

    // Data bits plus the optional ninth bit
    function automatic logic [3:0] frame_bits(input logic md, input logic par);
        return BITS_BASE + {3'b000, md | par};
    endfunction : frame_bits

    function automatic logic parity_of(input logic [7:0] data, input logic odd);
        return (^data) ^ odd;
    endfunction : parity_of

endpackage : asp_pkg

// ### design/asp_baud_gen.sv
`timescale 1ns/10ps
module asp_baud_gen #(
    parameter int unsigned DIV_W = asp_pkg::BRG_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } asp_brg_state_t;

    asp_brg_state_t s_q;
    asp_brg_state_t s_d;

    // Divisor of zero behaves like one, so the generator never stalls
    // A lowered divisor reloads at once instead of running out the old, longer count
    always_comb begin
        s_d = s_q;
        if (ce) begin
            if (s_q.cnt <= DIV_W'(1) || s_q.cnt > divisor) begin
                s_d.cnt = divisor;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - DIV_W'(1);
                s_d.tick = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    AST_BRG_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && ce && $stable(divisor) && divisor > DIV_W'(1)) |=> !tick)
        else $error("Divisor ticks closer than the divisor allows");

endmodule : asp_baud_gen

// ### design/asp_serial_port.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
module asp_serial_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic tx_irq_req,
    output logic rx_irq_req,
    output logic serial_tx_irq_flag,
    output logic serial_rx_irq_flag
);
    asp_pkg::asp_state_t s_q;
    asp_pkg::asp_state_t s_d;

    logic tick;
    logic [15:0] divisor;
    logic acc;
    logic rd_data;
    logic rd_stat;
    logic md;
    logic par_on;
    logic [3:0] nbits;
    logic rx_done;
    logic [7:0] rx_byte;
    logic rx_ninth;
    logic rx_brk;
    logic rx_perr;
    logic deliver;
    logic tx_req;
    logic rx_req;
    logic [7:0] stat0;

    assign divisor = {s_q.rate_hi, s_q.rate_lo};

    asp_baud_gen #(
        .DIV_W(asp_pkg::BRG_W)
    ) u_brg (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .divisor(divisor),
        .tick(tick)
    );

    assign acc = ce & hsel & htrans[1] & hready;
    assign rd_data = acc & !hwrite & asp_pkg::reg_hit(haddr, asp_pkg::IDX_DATA);
    assign rd_stat = acc & !hwrite & asp_pkg::reg_hit(haddr, asp_pkg::IDX_STAT0);
    assign md = s_q.ctl1[asp_pkg::MD_EN_BIT];
    // Multidrop marker takes the ninth slot, so parity is ignored there
    assign par_on = s_q.ctl0[asp_pkg::PAR_EN_BIT] & !md;
    assign nbits = asp_pkg::frame_bits(md, par_on);

    assign rx_done = (s_q.rx_st == asp_pkg::ASP_RX_STOP) && tick && (s_q.rx_tick == asp_pkg::TICK_LAST);
    assign rx_ninth = s_q.rx_shift[8];
    assign rx_byte = (md | par_on) ? s_q.rx_shift[7:0] : s_q.rx_shift[8:1];
    assign rx_brk = (rx_byte == 8'h00) && !serial_in_pin && !((md | par_on) && rx_ninth);
    assign rx_perr = par_on && (rx_ninth != asp_pkg::parity_of(rx_byte, s_q.ctl0[asp_pkg::PAR_ODD_BIT]));
    // Filtered multidrop: address bytes only steer the match, data needs a hit
    assign deliver = !(md && s_q.ctl1[asp_pkg::MD_FILT_BIT]) || (!rx_ninth && s_q.addr_hit);

    assign tx_req = s_q.ctl0[asp_pkg::TX_EN_BIT] & s_q.tx_empty;
    assign rx_req = (s_q.ctl0[asp_pkg::RX_EN_BIT] & ((s_q.rx_avail & !s_q.ctl1[asp_pkg::AVAIL_MASK_BIT])
        | s_q.overrun | s_q.framing | s_q.parity_err | s_q.line_break)) | s_q.timer_flag;

    always_comb begin
        stat0 = 8'h00;
        stat0[asp_pkg::ST_AVAIL_BIT] = s_q.rx_avail;
        stat0[asp_pkg::ST_PERR_BIT] = s_q.parity_err;
        stat0[asp_pkg::ST_OVR_BIT] = s_q.overrun;
        stat0[asp_pkg::ST_FERR_BIT] = s_q.framing;
        stat0[asp_pkg::ST_BRK_BIT] = s_q.line_break;
        stat0[asp_pkg::ST_TXE_BIT] = s_q.tx_empty;
        stat0[asp_pkg::ST_MARK_BIT] = s_q.rx_mark;
        stat0[asp_pkg::ST_TMR_BIT] = s_q.timer_flag;
    end

    always_comb begin
        s_d = s_q;
        if (ce) begin
            // Bus address phase: capture read data and apply read side effects
            if (acc) begin
                s_d.wr_pend = hwrite;
                s_d.wr_idx = haddr[13:2];
                s_d.hrdata = 8'h00;
                if (!hwrite) begin
                    if (rd_data) s_d.hrdata = s_q.rx_data;
                    if (rd_stat) s_d.hrdata = stat0;
                    if (asp_pkg::reg_hit(haddr, asp_pkg::IDX_CTL0)) s_d.hrdata = s_q.ctl0;
                    if (asp_pkg::reg_hit(haddr, asp_pkg::IDX_CTL1)) s_d.hrdata = s_q.ctl1;
                    if (asp_pkg::reg_hit(haddr, asp_pkg::IDX_MATCH)) s_d.hrdata = s_q.match;
                    if (asp_pkg::reg_hit(haddr, asp_pkg::IDX_RATE_HI)) s_d.hrdata = s_q.rate_hi;
                    if (asp_pkg::reg_hit(haddr, asp_pkg::IDX_RATE_LO)) s_d.hrdata = s_q.rate_lo;
                    if (asp_pkg::reg_hit(haddr, asp_pkg::IDX_INTERRUPT_REQUEST_REG_ZERO)) begin
                        s_d.hrdata[asp_pkg::IRQ_RX_BIT] = s_q.irq_rx;
                        s_d.hrdata[asp_pkg::IRQ_TX_BIT] = s_q.irq_tx;
                    end
                end
            end else begin
                s_d.wr_pend = 1'b0;
            end
            if (rd_stat) begin
                s_d.overrun = 1'b0;
                s_d.framing = 1'b0;
                s_d.parity_err = 1'b0;
                s_d.line_break = 1'b0;
                s_d.timer_flag = 1'b0;
            end
            if (rd_data) begin
                s_d.rx_avail = 1'b0;
                // Pending overrun is revealed only now, with a byte to discard
                if (s_q.ovr_pend) begin
                    s_d.overrun = 1'b1;
                    s_d.line_break = s_q.brk_pend;
                    s_d.rx_avail = 1'b1;
                    s_d.ovr_pend = 1'b0;
                    s_d.brk_pend = 1'b0;
                end
            end

            // Bus data phase: writes land one cycle after the address
            if (s_q.wr_pend) begin
                case (s_q.wr_idx)
                    asp_pkg::IDX_DATA: begin
                        s_d.tx_hold = hwdata[7:0];
                        s_d.hold_full = 1'b1;
                        s_d.tx_empty = 1'b0;
                    end
                    asp_pkg::IDX_CTL0: s_d.ctl0 = hwdata[7:0];
                    asp_pkg::IDX_CTL1: s_d.ctl1 = hwdata[7:0];
                    asp_pkg::IDX_MATCH: s_d.match = hwdata[7:0];
                    asp_pkg::IDX_RATE_HI: s_d.rate_hi = hwdata[7:0];
                    asp_pkg::IDX_RATE_LO: s_d.rate_lo = hwdata[7:0];
                    asp_pkg::IDX_INTERRUPT_REQUEST_REG_ZERO: begin
                        if (hwdata[asp_pkg::IRQ_RX_BIT]) s_d.irq_rx = 1'b0;
                        if (hwdata[asp_pkg::IRQ_TX_BIT]) s_d.irq_tx = 1'b0;
                    end
                    default: ;
                endcase
            end

            // Transmitter
            case (s_q.tx_st)
                asp_pkg::ASP_TX_IDLE: begin
                    if (s_q.ctl0[asp_pkg::TX_EN_BIT] && s_q.hold_full) begin
                        s_d.tx_shift = {md ? s_q.ctl1[asp_pkg::MD_TXMARK_BIT]
                            : asp_pkg::parity_of(s_q.tx_hold, s_q.ctl0[asp_pkg::PAR_ODD_BIT]), s_q.tx_hold};
                        s_d.hold_full = s_d.hold_full & s_q.wr_pend & (s_q.wr_idx == asp_pkg::IDX_DATA);
                        s_d.tx_st = asp_pkg::ASP_TX_START;
                        s_d.tx_tick = 4'h0;
                        s_d.tx_bit = 4'h0;
                    end
                end
                asp_pkg::ASP_TX_START: begin
                    if (tick) begin
                        s_d.tx_tick = s_q.tx_tick + 4'h1;
                        if (s_q.tx_tick == asp_pkg::TICK_LAST) s_d.tx_st = asp_pkg::ASP_TX_BITS;
                    end
                end
                asp_pkg::ASP_TX_BITS: begin
                    if (tick) begin
                        s_d.tx_tick = s_q.tx_tick + 4'h1;
                        if (s_q.tx_tick == asp_pkg::TICK_LAST) begin
                            s_d.tx_shift = {1'b1, s_q.tx_shift[8:1]};
                            s_d.tx_bit = s_q.tx_bit + 4'h1;
                            // Eight bit times, nine with a ninth bit, remain to refill the holding register
                            if (s_q.tx_bit == 4'h0 && !s_d.hold_full) s_d.tx_empty = 1'b1;
                            if (s_q.tx_bit == nbits - 4'h1) s_d.tx_st = asp_pkg::ASP_TX_STOP;
                        end
                    end
                end
                asp_pkg::ASP_TX_STOP: begin
                    if (tick) begin
                        s_d.tx_tick = s_q.tx_tick + 4'h1;
                        if (s_q.tx_tick == asp_pkg::TICK_LAST) s_d.tx_st = asp_pkg::ASP_TX_IDLE;
                    end
                end
                default: s_d.tx_st = asp_pkg::ASP_TX_IDLE;
            endcase
            case (s_d.tx_st)
                asp_pkg::ASP_TX_START: s_d.txd = 1'b0;
                asp_pkg::ASP_TX_BITS: s_d.txd = s_d.tx_shift[0];
                default: s_d.txd = 1'b1;
            endcase

            // Receiver
            case (s_q.rx_st)
                asp_pkg::ASP_RX_IDLE: begin
                    if (s_q.ctl0[asp_pkg::RX_EN_BIT] && !serial_in_pin) begin
                        s_d.rx_st = asp_pkg::ASP_RX_START;
                        s_d.rx_tick = 4'h0;
                    end
                end
                asp_pkg::ASP_RX_START: begin
                    if (tick) begin
                        s_d.rx_tick = s_q.rx_tick + 4'h1;
                        if (s_q.rx_tick == asp_pkg::TICK_MID) begin
                            // A start that is high again at mid bit was a glitch
                            s_d.rx_st = serial_in_pin ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_BITS;
                            s_d.rx_tick = 4'h0;
                            s_d.rx_bit = 4'h0;
                        end
                    end
                end
                asp_pkg::ASP_RX_BITS: begin
                    if (tick) begin
                        s_d.rx_tick = s_q.rx_tick + 4'h1;
                        if (s_q.rx_tick == asp_pkg::TICK_LAST) begin
                            s_d.rx_shift = {serial_in_pin, s_q.rx_shift[8:1]};
                            s_d.rx_bit = s_q.rx_bit + 4'h1;
                            if (s_q.rx_bit == nbits - 4'h1) s_d.rx_st = asp_pkg::ASP_RX_STOP;
                        end
                    end
                end
                asp_pkg::ASP_RX_STOP: begin
                    if (tick) begin
                        s_d.rx_tick = s_q.rx_tick + 4'h1;
                        if (rx_done) begin
                            s_d.rx_st = asp_pkg::ASP_RX_IDLE;
                            if (md && rx_ninth) s_d.addr_hit = (rx_byte == s_q.match);
                            if (deliver) begin
                                if (s_d.rx_avail) begin
                                    s_d.ovr_pend = 1'b1;
                                    s_d.brk_pend = s_q.brk_pend | rx_brk;
                                end else begin
                                    s_d.rx_data = rx_byte;
                                    s_d.rx_mark = rx_ninth;
                                    s_d.rx_avail = 1'b1;
                                    s_d.framing = s_d.framing | !serial_in_pin;
                                    s_d.parity_err = s_d.parity_err | rx_perr;
                                    s_d.line_break = s_d.line_break | rx_brk;
                                end
                            end
                        end
                    end
                end
                default: s_d.rx_st = asp_pkg::ASP_RX_IDLE;
            endcase

            if (tick && !s_q.ctl0[asp_pkg::TX_EN_BIT] && !s_q.ctl0[asp_pkg::RX_EN_BIT]
                && s_q.ctl1[asp_pkg::TMR_IRQ_BIT]) s_d.timer_flag = 1'b1;

            // Request edges set the flags; a set beats a same-cycle clear
            s_d.tx_req_prev = tx_req;
            s_d.rx_req_prev = rx_req;
            if (tx_req && !s_q.tx_req_prev) s_d.irq_tx = 1'b1;
            if (rx_req && !s_q.rx_req_prev) s_d.irq_rx = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.tx_st <= asp_pkg::ASP_TX_IDLE;
            s_q.rx_st <= asp_pkg::ASP_RX_IDLE;
            s_q.tx_empty <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.ctl0 <= asp_pkg::CTL0_RST;
            s_q.ctl1 <= asp_pkg::CTL1_RST;
            s_q.match <= asp_pkg::MATCH_RST;
            s_q.rate_hi <= asp_pkg::RATE_HI_RST;
            s_q.rate_lo <= asp_pkg::RATE_LO_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = {24'h0, s_q.hrdata};
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign serial_out_pin = s_q.txd;
    assign tx_irq_req = tx_req;
    assign rx_irq_req = rx_req;
    assign serial_tx_irq_flag = s_q.irq_tx;
    assign serial_rx_irq_flag = s_q.irq_rx;

    default clocking asp_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_TX_IDLE_HIGH: assert property ((s_q.tx_st == asp_pkg::ASP_TX_IDLE) |-> serial_out_pin)
        else $error("Line not idle high");
    AST_TX_START_LOW: assert property ((s_q.tx_st == asp_pkg::ASP_TX_START) |-> !serial_out_pin)
        else $error("Start bit not low");
    AST_WR_CLEARS_EMPTY: assert property ((ce && s_q.wr_pend && s_q.wr_idx == asp_pkg::IDX_DATA)
        |=> !s_q.tx_empty) else $error("Data write left holding empty set");
    AST_EMPTY_AFTER_BIT0: assert property ($rose(s_q.tx_empty) |->
        ($past(s_q.tx_st) == asp_pkg::ASP_TX_BITS && $past(s_q.tx_bit) == 4'h0 && s_q.tx_bit == 4'h1))
        else $error("Holding empty set outside first data bit end");
    AST_TX_DISABLED: assert property ((ce && !s_q.ctl0[asp_pkg::TX_EN_BIT] && s_q.tx_st == asp_pkg::ASP_TX_IDLE)
        |=> s_q.tx_st == asp_pkg::ASP_TX_IDLE) else $error("Transmit started while disabled");
    AST_TX_FLAG_ON_EDGE: assert property ((ce && tx_req && !s_q.tx_req_prev) |=> serial_tx_irq_flag)
        else $error("Transmit request edge did not set its flag");
    AST_OVR_KEEPS_BYTE: assert property ((ce && rx_done && deliver && s_q.rx_avail && !rd_data)
        |=> (s_q.rx_data == $past(s_q.rx_data)) && s_q.ovr_pend) else $error("Overrun overwrote held byte");
    AST_OVR_AFTER_READ: assert property ($rose(s_q.overrun) |-> ($past(rd_data) && s_q.rx_avail))
        else $error("Overrun shown before held byte was read");
    AST_RX_ERR_IRQ: assert property ((s_q.ctl0[asp_pkg::RX_EN_BIT] && (s_q.framing || s_q.overrun
        || s_q.line_break)) |-> rx_irq_req) else $error("Receive error without request");

endmodule : asp_serial_port

// ### testbench/asp_remote_station.sv
`timescale 1ns/10ps
module asp_remote_station #(
    parameter int BIT_CLKS = 16
) (
    input wire logic hclk,
    input wire logic serial_out_pin,
    output logic serial_in_pin,
    output logic [7:0] last_rx,
    output logic [7:0] frames
);
    logic [7:0] sh;
    initial begin
        serial_in_pin = 1'b1;
        last_rx = 8'h00;
        frames = 8'h00;
    end
    // Low start, LSB first, then the given stop level; a low stop is a deliberate fault
    task automatic send(input logic [7:0] data, input logic stop);
        logic [9:0] fr;
        fr = {stop, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_in_pin <= fr[i];
            repeat (BIT_CLKS) @(posedge hclk);
        end
        // A full idle bit follows: the stop bit when the last slot held a ninth bit
        serial_in_pin <= 1'b1;
        repeat (BIT_CLKS) @(posedge hclk);
    endtask : send
    // Mid-bit sampling; a frame with a low stop is not counted
    always begin
        @(negedge serial_out_pin);
        repeat (BIT_CLKS / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge hclk);
            sh[i] = serial_out_pin;
        end
        repeat (BIT_CLKS) @(posedge hclk);
        if (serial_out_pin === 1'b1) begin
            last_rx = sh;
            frames = frames + 8'h01;
        end
    end
endmodule : asp_remote_station

// ### testbench/tb_async_serial_port_tx_rx_irq.sv
`timescale 1ns/10ps
module tb_async_serial_port_tx_rx_irq;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdv;
    logic hreadyout, hresp, serial_in_pin, serial_out_pin, tx_irq_req, rx_irq_req;
    logic [7:0] last_rx, frames;
    logic tx_flag, rx_flag;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    always #2.5 hclk = ~hclk;
    asp_serial_port dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req),
        .serial_tx_irq_flag(tx_flag), .serial_rx_irq_flag(rx_flag));
    asp_remote_station st (.hclk(hclk), .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin),
        .last_rx(last_rx), .frames(frames));
    task automatic complete_run();
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk
    // Holds the address phase until ready, then the data phase until ready again
    task automatic bus(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : bus
    task automatic rd(input logic [11:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        chk(rdv & {24'h0, mask}, {24'h0, exp});
        chk({31'h0, hresp}, 32'h0);
    endtask : rd
    // Generous ceiling; the full sequence needs under 3000 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(asp_pkg::IDX_RATE_HI, 8'hff, 8'hff);
        rd(asp_pkg::IDX_RATE_LO, 8'hff, 8'hff);
        rd(asp_pkg::IDX_MATCH, 8'hff, 8'h00);
        rd(asp_pkg::IDX_STAT0, 8'hff, 8'h04);
        rd(12'hf44, 8'hff, 8'h00);
        bus(asp_pkg::IDX_RATE_HI, 1'b1, 8'h00);
        bus(asp_pkg::IDX_RATE_LO, 1'b1, 8'h01);
        bus(asp_pkg::IDX_MATCH, 1'b1, 8'h5a);
        rd(asp_pkg::IDX_MATCH, 8'hff, 8'h5a);
        bus(asp_pkg::IDX_CTL0, 1'b1, 8'h40);
        bus(asp_pkg::IDX_DATA, 1'b1, 8'ha5);
        rd(asp_pkg::IDX_STAT0, 8'h04, 8'h00);
        repeat (200) @(posedge hclk);
        chk({24'h0, frames}, 32'h0);
        bus(asp_pkg::IDX_CTL0, 1'b1, 8'hc0);
        repeat (200) @(posedge hclk);
        chk({24'h0, frames}, 32'h1);
        chk({24'h0, last_rx}, 32'ha5);
        chk({31'h0, tx_irq_req}, 32'h1);
        rd(asp_pkg::IDX_INTERRUPT_REQUEST_REG_ZERO, 8'h08, 8'h08);
        chk({31'h0, tx_flag}, 32'h1);
        bus(asp_pkg::IDX_INTERRUPT_REQUEST_REG_ZERO, 1'b1, 8'h08);
        rd(asp_pkg::IDX_INTERRUPT_REQUEST_REG_ZERO, 8'h08, 8'h00);
        st.send(8'h3c, 1'b1);
        chk({31'h0, rx_irq_req}, 32'h1);
        rd(asp_pkg::IDX_STAT0, 8'h80, 8'h80);
        rd(asp_pkg::IDX_DATA, 8'hff, 8'h3c);
        st.send(8'h11, 1'b1);
        st.send(8'h22, 1'b1);
        rd(asp_pkg::IDX_DATA, 8'hff, 8'h11);
        rd(asp_pkg::IDX_STAT0, 8'ha8, 8'ha0);
        rd(asp_pkg::IDX_DATA, 8'hff, 8'h11);
        bus(asp_pkg::IDX_INTERRUPT_REQUEST_REG_ZERO, 1'b1, 8'h10);
        st.send(8'h55, 1'b0);
        repeat (4) @(posedge hclk);
        rd(asp_pkg::IDX_DATA, 8'hff, 8'h55);
        chk({31'h0, rx_irq_req}, 32'h1);
        rd(asp_pkg::IDX_STAT0, 8'h10, 8'h10);
        chk({31'h0, rx_irq_req}, 32'h0);
        rd(asp_pkg::IDX_INTERRUPT_REQUEST_REG_ZERO, 8'h10, 8'h10);
        chk({31'h0, rx_flag}, 32'h1);
        // Even parity: 03 needs a low ninth bit, 07 a high one
        bus(asp_pkg::IDX_CTL0, 1'b1, 8'hd0);
        st.send(8'h03, 1'b1);
        rd(asp_pkg::IDX_STAT0, 8'h40, 8'h40);
        rd(asp_pkg::IDX_DATA, 8'hff, 8'h03);
        st.send(8'h07, 1'b1);
        rd(asp_pkg::IDX_STAT0, 8'hc0, 8'h80);
        rd(asp_pkg::IDX_DATA, 8'hff, 8'h07);
        // Filtered multidrop: data passes only after the matching address 5a
        bus(asp_pkg::IDX_CTL1, 1'b1, 8'hc0);
        st.send(8'h33, 1'b1);
        st.send(8'h44, 1'b0);
        rd(asp_pkg::IDX_STAT0, 8'h80, 8'h00);
        st.send(8'h5a, 1'b1);
        st.send(8'h77, 1'b0);
        chk({31'h0, rx_irq_req}, 32'h1);
        bus(asp_pkg::IDX_CTL1, 1'b1, 8'hd0);
        @(posedge hclk);
        chk({31'h0, rx_irq_req}, 32'h0);
        rd(asp_pkg::IDX_DATA, 8'hff, 8'h77);
        bus(asp_pkg::IDX_CTL1, 1'b1, 8'h08);
        bus(asp_pkg::IDX_CTL0, 1'b1, 8'h00);
        repeat (4) @(posedge hclk);
        chk({31'h0, rx_irq_req}, 32'h1);
        rd(asp_pkg::IDX_STAT0, 8'h01, 8'h01);
        complete_run();
    end
endmodule : tb_async_serial_port_tx_rx_irq
